//--- core/dac_top.sv
// Summary of operation
// - Two alarm channels, each set as high or low, rate or total, normally open or closed.
// - Each channel shows its alarm state on its own annunciator output.
// - The annunciator flashes while the activation wait or the mute period runs.
// - The total is sampled and compared only on the one-second tick.
// - Hysteresis applies only to rate channels; total channels have none.
// - A channel is switched on or off without touching its other settings.
// - Each channel stores a setpoint, an activation wait and a mute period.
// - With alarms fitted, the two alarm entries sit after clip-off and before the divider.
// - A high rate alarm sets at or above the setpoint and clears below setpoint minus width.
// - The output switches only after the activation wait, 0 to 3600 whole seconds.
// - The select key during an active alarm with a non-zero mute period mutes the output.
// - Changing a channel's rate or total type leaves it switched off until re-enabled.
`timescale 1ns/1ns
module dac_top #(
  parameter int unsigned TICK_CYCLES = dac_pkg::TICK_CYCLES_DEF
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic [dac_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Write protection
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [dac_pkg::DATA_W-1:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [dac_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Read protection
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [dac_pkg::DATA_W-1:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [dac_pkg::RATE_W-1:0] rate_value, // Live rate value
  input wire logic [dac_pkg::TOTAL_W-1:0] total_value, // Live total value
  input wire logic select_key, // Select key pulse
  input wire logic alarms_fitted, // Alarm option strap
  output logic [dac_pkg::NUM_CH-1:0] alarm_switch, // Switch closed when high
  output logic [dac_pkg::NUM_CH-1:0] annunciator // Segment lit when high
);

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction : merge

  function automatic logic [dac_pkg::TIME_W-1:0] clamp_time(input logic [31:0] v);
    return (v > 32'(dac_pkg::TIME_MAX)) ? dac_pkg::TIME_MAX : v[dac_pkg::TIME_W-1:0];
  endfunction : clamp_time

  dac_pkg::dac_cfg_type cfg_q [dac_pkg::NUM_CH];
  dac_pkg::dac_stat_type stat [dac_pkg::NUM_CH];
  logic tick;
  logic flash;
  logic [dac_pkg::TOTAL_W-1:0] total_snap_q;
  logic fitted_q;

  logic aw_have_q;
  logic w_have_q;
  logic [dac_pkg::ADDR_W-1:0] awaddr_q;
  logic [dac_pkg::DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;

  dac_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .tick(tick),
    .flash(flash)
  );

  for (genvar c = 0; c < dac_pkg::NUM_CH; c++)
  begin : g_ch
    dac_channel u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .tick(tick),
      .accept(select_key),
      .cfg(cfg_q[c]),
      .rate_value(rate_value),
      .total_value(total_value),
      .stat(stat[c])
    );
  end

  // Write address and data captured independently
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dac_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q[7:6] == 2'h0 && awaddr_q[4:0] <= dac_pkg::OFF_ENABLE[4:0]
                        && awaddr_q[1:0] == 2'h0) ? dac_pkg::RESP_OKAY : dac_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Channel settings
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int c = 0; c < dac_pkg::NUM_CH; c++)
        cfg_q[c] <= '0;
    end
    else if (ce && do_write && awaddr_q[7:6] == 2'h0)
    begin
      for (int c = 0; c < dac_pkg::NUM_CH; c++)
      begin
        if (awaddr_q[5] == c[0])
        begin
          case (awaddr_q[4:0])
            dac_pkg::OFF_CTRL[4:0]:
            begin
              logic [31:0] v;
              v = merge({29'h0, cfg_q[c].nc, cfg_q[c].total, cfg_q[c].high},
                        wdata_q, wstrb_q);
              cfg_q[c].high <= v[dac_pkg::CTRL_HIGH_BIT];
              cfg_q[c].total <= v[dac_pkg::CTRL_TOTAL_BIT];
              cfg_q[c].nc <= v[dac_pkg::CTRL_NC_BIT];
              if (v[dac_pkg::CTRL_TOTAL_BIT] != cfg_q[c].total)
                cfg_q[c].channel_on_item <= 1'b0;
            end
            dac_pkg::OFF_SETPOINT[4:0]:
              cfg_q[c].setpoint <= merge(cfg_q[c].setpoint, wdata_q, wstrb_q);
            dac_pkg::OFF_DEADBAND[4:0]:
            begin
              logic [31:0] v;
              v = merge({16'h0, cfg_q[c].deadband_width}, wdata_q, wstrb_q);
              cfg_q[c].deadband_width <= v[dac_pkg::RATE_W-1:0];
            end
            dac_pkg::OFF_WAIT[4:0]:
              cfg_q[c].activation_wait <= clamp_time(
                merge({20'h0, cfg_q[c].activation_wait}, wdata_q, wstrb_q));
            dac_pkg::OFF_MUTE[4:0]:
              cfg_q[c].mute_period <= clamp_time(
                merge({20'h0, cfg_q[c].mute_period}, wdata_q, wstrb_q));
            dac_pkg::OFF_ENABLE[4:0]:
              if (wstrb_q[0])
                cfg_q[c].channel_on_item <= wdata_q[0];
            default:
              ;
          endcase
        end
      end
    end
  end

  // Total sampled once per second for readback
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      total_snap_q <= '0;
    else if (ce && tick)
      total_snap_q <= total_value;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fitted_q <= 1'b0;
    else if (ce)
      fitted_q <= alarms_fitted;
  end

  // Pin outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alarm_switch <= '0;
      annunciator <= '0;
    end
    else if (ce)
    begin
      for (int c = 0; c < dac_pkg::NUM_CH; c++)
      begin
        alarm_switch[c] <= stat[c].alarm ^ cfg_q[c].nc;
        annunciator[c] <= stat[c].indicate
                          && (flash || !(stat[c].delaying || stat[c].silenced));
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= dac_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        logic ci;
        ci = s_axi_araddr[5];
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= dac_pkg::RESP_OKAY;
        s_axi_rdata <= '0;
        if (s_axi_araddr[7:6] == 2'h0)
        begin
          case (s_axi_araddr[4:0])
            dac_pkg::OFF_CTRL[4:0]:
              s_axi_rdata <= {29'h0, cfg_q[ci].nc, cfg_q[ci].total, cfg_q[ci].high};
            dac_pkg::OFF_SETPOINT[4:0]:
              s_axi_rdata <= cfg_q[ci].setpoint;
            dac_pkg::OFF_DEADBAND[4:0]:
              s_axi_rdata <= {16'h0, cfg_q[ci].deadband_width};
            dac_pkg::OFF_WAIT[4:0]:
              s_axi_rdata <= {20'h0, cfg_q[ci].activation_wait};
            dac_pkg::OFF_MUTE[4:0]:
              s_axi_rdata <= {20'h0, cfg_q[ci].mute_period};
            dac_pkg::OFF_ENABLE[4:0]:
              s_axi_rdata <= {31'h0, cfg_q[ci].channel_on_item};
            default:
              s_axi_rresp <= dac_pkg::RESP_SLVERR;
          endcase
        end
        else if (s_axi_araddr == dac_pkg::ADDR_STATUS)
          s_axi_rdata <= {24'h0, stat[1], stat[0]};
        else if (s_axi_araddr == dac_pkg::ADDR_TOTAL)
          s_axi_rdata <= total_snap_q;
        else if (s_axi_araddr == dac_pkg::ADDR_MENU)
        begin
          if (fitted_q)
            s_axi_rdata <= {dac_pkg::MENU_CLIP_IDX + 8'h03, dac_pkg::MENU_CLIP_IDX + 8'h02,
                            dac_pkg::MENU_CLIP_IDX + dac_pkg::MENU_STEP,
                            dac_pkg::MENU_CLIP_IDX};
          else
            s_axi_rdata <= {dac_pkg::MENU_CLIP_IDX + dac_pkg::MENU_STEP, 16'h0,
                            dac_pkg::MENU_CLIP_IDX};
        end
        else
          s_axi_rresp <= dac_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : dac_top

//--- core/dac_pkg.sv
package dac_pkg;

  localparam int unsigned NUM_CH = 2;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES_DEF = TICK_S * CLK_HZ;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RATE_W = 16;
  localparam int unsigned TOTAL_W = 32;
  localparam int unsigned TIME_W = 12;
  localparam int unsigned MENU_W = 8;

  localparam logic [TIME_W-1:0] TIME_MAX = 12'hE10;

  // Channel windows
  localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SETPOINT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DEADBAND = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_WAIT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_MUTE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_TOTAL = 8'h44;
  localparam logic [ADDR_W-1:0] ADDR_MENU = 8'h48;

  localparam int unsigned CTRL_HIGH_BIT = 0;
  localparam int unsigned CTRL_TOTAL_BIT = 1;
  localparam int unsigned CTRL_NC_BIT = 2;
  localparam int unsigned STAT_BITS = 4;

  localparam logic [MENU_W-1:0] MENU_CLIP_IDX = 8'h0A;
  localparam logic [MENU_W-1:0] MENU_STEP = 8'h01;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic channel_on_item;
    logic high;
    logic total;
    logic nc;
    logic [TOTAL_W-1:0] setpoint;
    logic [RATE_W-1:0] deadband_width;
    logic [TIME_W-1:0] activation_wait;
    logic [TIME_W-1:0] mute_period;
  } dac_cfg_type;

  typedef struct packed {
    logic silenced;
    logic delaying;
    logic indicate;
    logic alarm;
  } dac_stat_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_MUTED = 2'b11
  } dac_state_type;

endpackage : dac_pkg

//--- core/dac_tick.sv
`timescale 1ns/1ns
module dac_tick #(
  parameter int unsigned TICK_CYCLES = dac_pkg::TICK_CYCLES_DEF
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic ce, // Clock enable
  output logic tick, // One-cycle pulse per second
  output logic flash // Half-second blink phase
);

  localparam logic [31:0] LAST = 32'(TICK_CYCLES - 1);
  localparam logic [31:0] HALF = 32'(TICK_CYCLES / 2);

  logic [31:0] cnt_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
      flash <= 1'b0;
    end
    else if (ce)
    begin
      tick <= (cnt_q == LAST);
      if (cnt_q == LAST)
      begin
        cnt_q <= 32'h0;
        flash <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + 32'h1;
        if (cnt_q == HALF)
          flash <= 1'b0;
      end
    end
  end

endmodule : dac_tick

//--- core/dac_channel.sv
`timescale 1ns/1ns
module dac_channel (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic tick, // Second tick
  input wire logic accept, // Select key pulse
  input wire dac_pkg::dac_cfg_type cfg, // Channel settings
  input wire logic [dac_pkg::RATE_W-1:0] rate_value, // Rate value
  input wire logic [dac_pkg::TOTAL_W-1:0] total_value, // Total value
  output dac_pkg::dac_stat_type stat // Channel state
);

  dac_pkg::dac_state_type state_q;
  logic [dac_pkg::TIME_W-1:0] cnt_q;
  logic [dac_pkg::TOTAL_W:0] value;
  logic [dac_pkg::TOTAL_W:0] sp;
  logic [dac_pkg::TOTAL_W:0] hy;
  logic cond;
  logic evaluate;

  always_comb
  begin
    value = cfg.total ? {1'b0, total_value} : {17'h0, rate_value};
    sp = {1'b0, cfg.setpoint};
    hy = cfg.total ? 33'h0 : {17'h0, cfg.deadband_width};
    if (state_q == dac_pkg::ST_IDLE)
      cond = cfg.high ? (value >= sp) : (value <= sp);
    else if (cfg.high)
      cond = !((value + hy) < sp);
    else
      cond = !(value > (sp + hy));
    evaluate = !cfg.total || tick;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= dac_pkg::ST_IDLE;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      if (!cfg.channel_on_item)
        state_q <= dac_pkg::ST_IDLE;
      else if (evaluate && !cond)
        state_q <= dac_pkg::ST_IDLE;
      else
      begin
        case (state_q)
          dac_pkg::ST_IDLE:
          begin
            if (evaluate && cond)
            begin
              cnt_q <= cfg.activation_wait;
              state_q <= (cfg.activation_wait == '0) ? dac_pkg::ST_ACTIVE
                                                     : dac_pkg::ST_WAIT;
            end
          end
          dac_pkg::ST_WAIT:
          begin
            if (tick)
            begin
              // Full seconds only: the first tick may come at once
              if (cnt_q == '0)
                state_q <= dac_pkg::ST_ACTIVE;
              else
                cnt_q <= cnt_q - 12'h001;
            end
          end
          dac_pkg::ST_ACTIVE:
          begin
            if (accept && cfg.mute_period != '0)
            begin
              cnt_q <= cfg.mute_period;
              state_q <= dac_pkg::ST_MUTED;
            end
          end
          dac_pkg::ST_MUTED:
          begin
            if (tick)
            begin
              if (cnt_q == '0)
                state_q <= dac_pkg::ST_ACTIVE;
              else
                cnt_q <= cnt_q - 12'h001;
            end
          end
          default:
            state_q <= dac_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_comb
  begin
    stat.alarm = (state_q == dac_pkg::ST_ACTIVE);
    stat.indicate = (state_q != dac_pkg::ST_IDLE);
    stat.delaying = (state_q == dac_pkg::ST_WAIT);
    stat.silenced = (state_q == dac_pkg::ST_MUTED);
  end

endmodule : dac_channel

//--- verification/dac_keypad_load.sv
`timescale 1ns/1ns
module dac_keypad_load (
  input wire logic aclk, // System clock
  input wire logic press_req, // Operator presses the key
  input wire logic [1:0] alarm_switch, // Switch state from the block
  output logic select_key, // Key line into the block
  output logic [1:0] load_on // Current flows in the load
);
  // Key contact seen one cycle after the press
  always_ff @(posedge aclk)
  begin
    select_key <= press_req;
  end

  // Load is energised while the switch is closed
  assign load_on = alarm_switch;
endmodule : dac_keypad_load

//--- verification/dac_top_checker.sv
`timescale 1ns/1ns
module dac_top_checker #(
  parameter int unsigned TICK_CYCLES = 20
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic ce, // Clock enable
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic [1:0] s_axi_bresp, // B response
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic [1:0] s_axi_rresp, // R response
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic [1:0] alarm_switch, // Switches
  input wire logic [1:0] annunciator // Segments
);
  reset_outs_a: assert property (@(posedge aclk) disable iff (1'b0)
    (!aresetn && ce) |=> (alarm_switch == 2'h0 && annunciator == 2'h0 && !s_axi_bvalid))
    else $error("outputs not cleared by reset");
  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped early");
  rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read data dropped early");
  rd_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && ce) |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce) |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  aw_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_awvalid && s_axi_awready && ce) |=> !s_axi_awready)
    else $error("second write address accepted");
  ar_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answering");
  w_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write accepted while answering");
endmodule : dac_top_checker

//--- verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int unsigned TC = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, key;
  logic [1:0] bresp, rresp, sw, ann, load;
  logic [31:0] rdata, d;
  logic [1:0] r;
  logic [15:0] rate = 16'h0;
  logic [31:0] total = 32'h0;
  logic fitted = 1'b1;
  logic press = 1'b0;
  logic ce = 1'b1;
  int errors = 0;
  int num_checks = 0;

  always #5 aclk = ~aclk;

  dac_top #(.TICK_CYCLES(TC)) i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rate_value(rate), .total_value(total), .select_key(key),
    .alarms_fitted(fitted), .alarm_switch(sw), .annunciator(ann));

  dac_keypad_load i_keys (.aclk(aclk), .press_req(press), .alarm_switch(sw),
    .select_key(key), .load_on(load));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      aw_ok = aw_ok || awready;
      w_ok = w_ok || wready;
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", {30'h0, dac_pkg::RESP_OKAY}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic wait_sw(input int ch, input logic v, input int lim, input string nm);
    int n;
    n = 0;
    while (load[ch] !== v && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    chk(nm, {31'h0, v}, {31'h0, load[ch]});
  endtask : wait_sw

  task automatic flash(input string nm);
    int c;
    c = 0;
    repeat (12)
    begin
      @(posedge aclk);
      c += ann[0];
    end
    chk(nm, 32'h1, {31'h0, c > 0 && c < 12});
  endtask : flash

  task automatic setup(input logic [7:0] b, input logic [31:0] c, input logic [31:0] sp);
    wr(b + dac_pkg::OFF_CTRL, c);
    wr(b + dac_pkg::OFF_SETPOINT, sp);
    wr(b + dac_pkg::OFF_DEADBAND, 32'hA);
    wr(b + dac_pkg::OFF_ENABLE, 32'h1);
  endtask : setup

  task automatic test_menu;
    rd(dac_pkg::ADDR_MENU);
    chk("menu fitted", 32'h0D0C0B0A, d);
    fitted <= 1'b0;
    cyc(3);
    rd(dac_pkg::ADDR_MENU);
    chk("menu bare", 32'h0B00000A, d);
    fitted <= 1'b1;
    rd(8'h80);
    chk("unmapped resp", {30'h0, dac_pkg::RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
  endtask : test_menu

  task automatic test_rate;
    setup(8'h00, 32'h1, 32'h64);
    setup(8'h20, 32'h4, 32'h32);
    rate <= 16'h0063;
    cyc(4);
    chk("sw below", 32'h2, {30'h0, load});
    rate <= 16'h0064;
    cyc(4);
    chk("sw at setpoint", 32'h3, {30'h0, load});
    rate <= 16'h005A;
    cyc(4);
    chk("sw in band", 32'h3, {30'h0, load});
    rate <= 16'h0059;
    cyc(4);
    chk("sw released", 32'h2, {30'h0, load});
    rate <= 16'h0032;
    cyc(4);
    chk("sw low alarm", 32'h0, {30'h0, load});
    chk("ann steady", 32'h2, {30'h0, ann});
    ce <= 1'b0;
    rate <= 16'h0040;
    cyc(4);
    chk("sw frozen", 32'h0, {30'h0, load});
    ce <= 1'b1;
    cyc(4);
    chk("sw low released", 32'h2, {30'h0, load});
    wr(8'h20 + dac_pkg::OFF_ENABLE, 32'h0);
    cyc(4);
    chk("sw disabled", 32'h2, {30'h0, load});
    rd(8'h20 + dac_pkg::OFF_SETPOINT);
    chk("setpoint kept", 32'h32, d);
    wr(8'h20 + dac_pkg::OFF_WAIT, 32'hFA0);
    rd(8'h20 + dac_pkg::OFF_WAIT);
    chk("wait limit", 32'hE10, d);
  endtask : test_rate

  task automatic test_total;
    wr(dac_pkg::OFF_CTRL, 32'h3);
    rd(dac_pkg::OFF_ENABLE);
    chk("type change off", 32'h0, d);
    wr(dac_pkg::OFF_ENABLE, 32'h1);
    total <= 32'h64;
    wait_sw(0, 1'b1, TC + 6, "total alarm");
    total <= 32'h5F;
    wait_sw(0, 1'b0, TC + 6, "total clear");
  endtask : test_total

  task automatic test_delay;
    wr(dac_pkg::OFF_CTRL, 32'h1);
    wr(dac_pkg::OFF_WAIT, 32'h2);
    wr(dac_pkg::OFF_ENABLE, 32'h1);
    rate <= 16'h0064;
    cyc(3);
    flash("wait flash");
    chk("sw held off", 32'h0, {31'h0, load[0]});
    wait_sw(0, 1'b1, 3 * TC + 6, "sw after wait");
    wr(dac_pkg::OFF_MUTE, 32'h2);
    press <= 1'b1;
    @(posedge aclk);
    press <= 1'b0;
    cyc(4);
    chk("sw muted", 32'h0, {31'h0, load[0]});
    flash("mute flash");
    wait_sw(0, 1'b1, 3 * TC + 6, "sw after mute");
  endtask : test_delay

  task automatic finish_test;
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  initial
  begin
    cyc(2);
    chk("reset sw", 32'h0, {30'h0, load});
    chk("reset ann", 32'h0, {30'h0, ann});
    aresetn <= 1'b1;
    cyc(2);
    test_menu();
    test_rate();
    test_total();
    test_delay();
    finish_test();
  end

  initial
  begin
    cyc(6000);
    errors++;
    finish_test();
  end
endmodule : testbench

bind dac_top dac_top_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.aclk(aclk),
  .aresetn(aresetn), .ce(ce), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .alarm_switch(alarm_switch),
  .annunciator(annunciator));
